//--- design/dcir_ahb_slave.sv
module dcir_ahb_slave (
    input  wire logic                  i_mclk,
    input  wire logic                  i_srst,
    input  wire logic                  i_hsel,
    input  wire logic [11:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic                  i_hready,
    output dcir_pkg::dcir_aphase_t     o_aphase,
    output logic      [11:0]           o_rd_addr,
    output logic                       o_rd_req
);

    dcir_pkg::dcir_aphase_t aph_reg;
    dcir_pkg::dcir_aphase_t aph_next;
    logic                   take;

    // Address phase taken only when selected, the bus is ready and the transfer is NONSEQ
    assign take     = i_hsel && i_hready && (i_htrans == dcir_pkg::HTRANS_NONSEQ);
    assign aph_next = take ? '{valid: 1'b1, write: i_hwrite, addr: {i_haddr[11:2], 2'b00}}
                           : (i_hready ? '0 : aph_reg);

    // Holding register for the data phase
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            aph_reg <= '0;
        end else begin
            aph_reg <= aph_next;
        end
    end

    // Read address handed early so read data lands with the data phase
    assign o_aphase  = aph_reg;
    assign o_rd_addr = {i_haddr[11:2], 2'b00};
    assign o_rd_req  = take && !i_hwrite;

endmodule : dcir_ahb_slave

//--- design/dcir_pkg.sv
package dcir_pkg;

    // Channel count and register widths
    localparam int          NUM_CH         = 4;
    localparam int          DATA_W         = 32;

    // Register byte offsets (word aligned)
    localparam logic [11:0] OFF_IVEC       = 12'h000;
    localparam logic [11:0] OFF_TX_MASKED  = 12'h004;
    localparam logic [11:0] OFF_TX_RAW     = 12'h008;
    localparam logic [11:0] OFF_TX_EN_SET  = 12'h00c;
    localparam logic [11:0] OFF_TX_EN_CLR  = 12'h010;
    localparam logic [11:0] OFF_RX_CTRL    = 12'h014;

    // Field positions and reset values
    localparam int          RX_ON_BIT      = 0;
    localparam logic [3:0]  TX_RAW_RST     = 4'h0;
    localparam logic [3:0]  TX_EN_RST      = 4'h0;
    localparam logic        RX_ON_RST      = 1'b0;
    localparam logic [31:0] IVEC_RST       = 32'h0000_0000;

    // AHB transfer type and response encodings
    localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    // Latched address phase of one AHB transfer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } dcir_aphase_t;

    // Decoded write strobes for the block's registers
    typedef struct packed {
        logic tx_en_set;
        logic tx_en_clr;
        logic tx_raw_clr;
        logic rx_ctrl;
    } dcir_wstb_t;

endpackage : dcir_pkg

//--- design/dcir_regs.sv
module dcir_regs #(
    parameter int NUM_CH = dcir_pkg::NUM_CH
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_srst,
    // AHB-Lite slave
    input  wire logic                  i_hsel,
    input  wire logic [11:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    // Interface core side
    input  wire logic [31:0]           i_intr_vector,
    input  wire logic [NUM_CH-1:0]     i_tx_done,
    output logic      [NUM_CH-1:0]     o_tx_irq,
    output logic                       o_rx_dma_on
);

    dcir_pkg::dcir_aphase_t aph;
    dcir_pkg::dcir_wstb_t   wstb;
    logic [11:0]            rd_addr;
    logic                   rd_req;

    logic [31:0]            ivec_reg;
    logic [NUM_CH-1:0]      tx_raw_reg;
    logic [NUM_CH-1:0]      tx_raw_next;
    logic [NUM_CH-1:0]      tx_en_reg;
    logic [NUM_CH-1:0]      tx_en_next;
    logic [NUM_CH-1:0]      tx_masked;
    logic [NUM_CH-1:0]      wr_bits;
    logic                   rx_on_reg;
    logic                   rx_on_next;
    logic [31:0]            hrdata_reg;
    logic [31:0]            hrdata_next;
    logic                   hready_reg;
    logic                   hresp_reg;
    logic [31:0]            rd_mux;
    logic [NUM_CH-1:0]      irq_reg;
    logic                   wr_ok;

    // Widen a channel vector into a read word, upper bits zero
    function automatic logic [31:0] zext(input logic [NUM_CH-1:0] v);
        zext = '0;
        zext[NUM_CH-1:0] = v;
    endfunction : zext

    dcir_ahb_slave u_slave (
        .i_mclk   (i_mclk),
        .i_srst   (i_srst),
        .i_hsel   (i_hsel),
        .i_haddr  (i_haddr),
        .i_htrans (i_htrans),
        .i_hwrite (i_hwrite),
        .i_hready (i_hready),
        .o_aphase (aph),
        .o_rd_addr(rd_addr),
        .o_rd_req (rd_req)
    );

    // Write strobe decode in the data phase
    // Size is not checked: software must use whole-word writes
    assign wr_ok          = aph.valid && aph.write;
    assign wr_bits        = i_hwdata[NUM_CH-1:0];
    assign wstb.tx_en_set = wr_ok && (aph.addr == dcir_pkg::OFF_TX_EN_SET);
    assign wstb.tx_en_clr = wr_ok && (aph.addr == dcir_pkg::OFF_TX_EN_CLR);
    assign wstb.tx_raw_clr = 1'b0;  // Raw flags are read-only here
    assign wstb.rx_ctrl   = wr_ok && (aph.addr == dcir_pkg::OFF_RX_CTRL);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ivec_reg <= dcir_pkg::IVEC_RST;
        end else begin
            ivec_reg <= i_intr_vector;
        end
    end

    // sticky completion flags
    // Flags stay set; clearing belongs to the end-of-interrupt logic outside
    assign tx_raw_next = tx_raw_reg | i_tx_done;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tx_raw_reg <= dcir_pkg::TX_RAW_RST;
        end else begin
            tx_raw_reg <= tx_raw_next;
        end
    end

    // set view sets
    // Set wins when set and clear hit the same cycle (cannot, one bus)
    assign tx_en_next = (tx_en_reg & ~({NUM_CH{wstb.tx_en_clr}} & wr_bits))
                      | ({NUM_CH{wstb.tx_en_set}} & wr_bits);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tx_en_reg <= dcir_pkg::TX_EN_RST;
        end else begin
            tx_en_reg <= tx_en_next;
        end
    end

    assign tx_masked = tx_raw_reg & tx_en_reg;

    // gated interrupt lines, registered for clean outputs
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= tx_masked;
        end
    end

    // receive engine enable
    // Feedback mux instead of a clock enable, so every flop runs each edge
    assign rx_on_next = wstb.rx_ctrl ? i_hwdata[dcir_pkg::RX_ON_BIT] : rx_on_reg;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rx_on_reg <= dcir_pkg::RX_ON_RST;
        end else begin
            rx_on_reg <= rx_on_next;
        end
    end

    // Read mux; enable views both read back the enable register
    assign rd_mux = (rd_addr == dcir_pkg::OFF_IVEC)      ? ivec_reg :
                    (rd_addr == dcir_pkg::OFF_TX_MASKED) ? zext(tx_masked) :
                    (rd_addr == dcir_pkg::OFF_TX_RAW)    ? zext(tx_raw_reg) :
                    (rd_addr == dcir_pkg::OFF_TX_EN_SET) ? zext(tx_en_reg) :
                    (rd_addr == dcir_pkg::OFF_TX_EN_CLR) ? zext(tx_en_reg) :
                    (rd_addr == dcir_pkg::OFF_RX_CTRL)   ? {31'h0000_0000, rx_on_reg} :
                    32'h0000_0000;

    // Read data captured at the address phase; unmapped reads give zero
    // Held between reads so a slow master can still take it late
    assign hrdata_next = rd_req ? rd_mux : hrdata_reg;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            hrdata_reg <= '0;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    // Zero wait states, always OKAY
    // Kept as flops so every top output is registered; ready stays high in reset
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            hready_reg <= 1'b1;
            hresp_reg  <= dcir_pkg::HRESP_OKAY;
        end else begin
            hready_reg <= 1'b1;
            hresp_reg  <= dcir_pkg::HRESP_OKAY;
        end
    end

    // Output ports straight from the flops
    assign o_hrdata    = hrdata_reg;
    assign o_hreadyout = hready_reg;
    assign o_hresp     = hresp_reg;
    assign o_tx_irq    = irq_reg;
    assign o_rx_dma_on = rx_on_reg;

    // Assertions
    // copy lags input by one cycle
    a_ivec_copy: assert property (@(posedge i_mclk) disable iff (i_srst)
        !$past(i_srst) |-> ivec_reg == $past(i_intr_vector))
        else $error("vector copy mismatch");

    a_raw_set: assert property (@(posedge i_mclk) disable iff (i_srst)
        i_tx_done[0] |=> tx_raw_reg[0])
        else $error("raw flag not set");

    a_raw_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
        tx_raw_reg[1] |=> tx_raw_reg[1][*3])
        else $error("raw flag dropped");

    a_irq_mask: assert property (@(posedge i_mclk) disable iff (i_srst)
        1'b1 |=> o_tx_irq == $past(tx_raw_reg & tx_en_reg))
        else $error("irq not masked status");

    a_irq_gated: assert property (@(posedge i_mclk) disable iff (i_srst)
        (tx_en_reg[2] == 1'b0) [*2] |-> !o_tx_irq[2])
        else $error("irq without enable");

    a_en_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
        wstb.tx_en_clr && i_hwdata[1] |=> !tx_en_reg[1])
        else $error("enable not cleared");

    a_en_set: assert property (@(posedge i_mclk) disable iff (i_srst)
        wstb.tx_en_set && i_hwdata[3] |=> tx_en_reg[3])
        else $error("enable not set");

    a_en_keep: assert property (@(posedge i_mclk) disable iff (i_srst)
        (wstb.tx_en_set || wstb.tx_en_clr) && i_hwdata[NUM_CH-1:0] == '0
        |=> $stable(tx_en_reg))
        else $error("zero write moved enables");

    a_rx_ctrl: assert property (@(posedge i_mclk) disable iff (i_srst)
        wstb.rx_ctrl |=> o_rx_dma_on == $past(i_hwdata[0]))
        else $error("rx enable wrong");

    a_ivec_read: assert property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_IVEC |=> o_hrdata == $past(ivec_reg))
        else $error("vector read wrong");

    a_raw_read: assert property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_TX_RAW |=> o_hrdata == zext($past(tx_raw_reg)))
        else $error("raw read wrong");

    // flag only rises on a done pulse
    a_raw_cause: assert property (@(posedge i_mclk) disable iff (i_srst)
        !tx_raw_reg[2] && !i_tx_done[2] |=> !tx_raw_reg[2])
        else $error("raw flag set without done");

    // masked read is raw AND enable
    a_masked_read: assert property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_TX_MASKED |=> o_hrdata == zext($past(tx_raw_reg & tx_en_reg)))
        else $error("masked read wrong");

    a_irq_follow: assert property (@(posedge i_mclk) disable iff (i_srst)
        tx_raw_reg[1] && tx_en_reg[1] |=> o_tx_irq[1])
        else $error("irq missing");

    a_en_read: assert property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_TX_EN_CLR |=> o_hrdata == zext($past(tx_en_reg)))
        else $error("enable read wrong");

    a_en_idle: assert property (@(posedge i_mclk) disable iff (i_srst)
        !wstb.tx_en_set && !wstb.tx_en_clr |=> $stable(tx_en_reg))
        else $error("enable moved without write");

    a_clear_other: assert property (@(posedge i_mclk) disable iff (i_srst)
        wstb.tx_en_clr && !i_hwdata[0] |=> tx_en_reg[0] == $past(tx_en_reg[0]))
        else $error("clear hit wrong bit");

    a_set_other: assert property (@(posedge i_mclk) disable iff (i_srst)
        wstb.tx_en_set && !i_hwdata[2] |=> tx_en_reg[2] == $past(tx_en_reg[2]))
        else $error("set hit wrong bit");

    a_rx_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        !wstb.rx_ctrl |=> $stable(o_rx_dma_on))
        else $error("rx enable moved");

    a_rx_read: assert property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_RX_CTRL |=> o_hrdata == {31'h0000_0000, $past(o_rx_dma_on)})
        else $error("rx control read wrong");

    // Read data holds between reads
    a_rdata_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        !rd_req |=> $stable(o_hrdata))
        else $error("read data moved");

    // Bus always ready and OKAY
    a_bus_okay: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_hreadyout && o_hresp == dcir_pkg::HRESP_OKAY)
        else $error("bus not ready or not okay");

    c_irq_raise: cover property (@(posedge i_mclk) disable iff (i_srst)
        i_tx_done[0] && tx_en_reg[0] ##2 o_tx_irq[0]);
    c_en_set_clr: cover property (@(posedge i_mclk) disable iff (i_srst)
        wstb.tx_en_set ##[1:20] wstb.tx_en_clr);
    c_rx_on: cover property (@(posedge i_mclk) disable iff (i_srst)
        $rose(o_rx_dma_on));
    c_rx_off: cover property (@(posedge i_mclk) disable iff (i_srst)
        $fell(o_rx_dma_on));
    c_masked_read: cover property (@(posedge i_mclk) disable iff (i_srst)
        rd_req && rd_addr == dcir_pkg::OFF_TX_MASKED && tx_masked != '0);

endmodule : dcir_regs

//--- test/dcir_regs_tb.sv
module dcir_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic              i_mclk;
    logic              i_srst;
    logic              i_hsel;
    logic              i_hwrite;
    logic [11:0]       i_haddr;
    logic [1:0]        i_htrans;
    logic [2:0]        i_hsize;
    logic [31:0]       i_hwdata;
    logic [31:0]       i_intr_vector;
    logic [3:0]        i_tx_done;
    wire logic [31:0]  o_hrdata;
    wire logic         o_hreadyout;
    wire logic         o_hresp;
    wire logic [3:0]   o_tx_irq;
    wire logic         o_rx_dma_on;
    logic [31:0]       rd;
    int                bad_count;
    int                tests_run;

    // Single slave, so its hreadyout is the bus hready
    dcir_regs u_dcir_regs (
        .i_mclk        (i_mclk),
        .i_srst        (i_srst),
        .i_hsel        (i_hsel),
        .i_haddr       (i_haddr),
        .i_htrans      (i_htrans),
        .i_hwrite      (i_hwrite),
        .i_hsize       (i_hsize),
        .i_hwdata      (i_hwdata),
        .i_hready      (o_hreadyout),
        .o_hrdata      (o_hrdata),
        .o_hreadyout   (o_hreadyout),
        .o_hresp       (o_hresp),
        .i_intr_vector (i_intr_vector),
        .i_tx_done     (i_tx_done),
        .o_tx_irq      (o_tx_irq),
        .o_rx_dma_on   (o_rx_dma_on)
    );

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task summarize;
        $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bounded wait for hready at a rising edge; a hang ends the run
    task wait_ready;
        int n;
        n = 0;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                summarize();
            end
            @(posedge i_mclk);
        end
    endtask : wait_ready

    // One single-word transfer: address phase, then data phase
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        i_haddr  <= a;
        i_hwrite <= w;
        i_htrans <= dcir_pkg::HTRANS_NONSEQ;
        wait_ready();
        i_htrans <= dcir_pkg::HTRANS_IDLE;
        i_hwdata <= wd;
        wait_ready();
        rd = o_hrdata;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk

    task pulse(input logic [3:0] v);
        i_tx_done <= v;
        @(posedge i_mclk);
        i_tx_done <= 4'h0;
        @(posedge i_mclk);
    endtask : pulse

    // Reset held ten cycles; first request after the release edge
    task do_reset;
        i_srst <= 1'b1;
        repeat (10) @(posedge i_mclk);
        i_srst <= 1'b0;
        @(posedge i_mclk);
    endtask : do_reset

    task after_reset(input string s);
        for (int i = 0; i < 7; i++) begin
            rdchk(12'(i * 4), 32'h0000_0000);
        end
        check({25'h0, o_hreadyout, o_hresp, o_tx_irq, o_rx_dma_on}, 32'h0000_0040);
        $display("test %s done", s);
    endtask : after_reset

    initial begin
        i_srst = 1'b1; i_hsel = 1'b1; i_hwrite = 1'b0; i_haddr = 12'h000;
        i_htrans = dcir_pkg::HTRANS_IDLE; i_hsize = 3'h2; i_hwdata = 32'h0000_0000;
        i_intr_vector = 32'h0000_0000; i_tx_done = 4'h0; bad_count = 0; tests_run = 0;
        do_reset();
        after_reset("reset");
        // Vector copy follows the input, including a change between reads
        i_intr_vector <= 32'hdead_beef;
        @(posedge i_mclk);
        rdchk(dcir_pkg::OFF_IVEC, 32'hdead_beef);
        i_intr_vector <= 32'h0123_4567;
        @(posedge i_mclk);
        rdchk(dcir_pkg::OFF_IVEC, 32'h0123_4567);
        $display("test vector done");
        // Set and clear views, zeros and reserved bits change nothing
        wr(dcir_pkg::OFF_TX_EN_SET, 32'h0000_0005);
        wr(dcir_pkg::OFF_TX_EN_SET, 32'h0000_0000);
        wr(dcir_pkg::OFF_TX_EN_CLR, 32'h0000_0000);
        rdchk(dcir_pkg::OFF_TX_EN_SET, 32'h0000_0005);
        wr(dcir_pkg::OFF_TX_EN_CLR, 32'h0000_0001);
        rdchk(dcir_pkg::OFF_TX_EN_CLR, 32'h0000_0004);
        wr(dcir_pkg::OFF_TX_EN_SET, 32'hffff_fffa);
        rdchk(dcir_pkg::OFF_TX_EN_SET, 32'h0000_000e);
        $display("test enables done");
        // Completion flags are sticky; masked view gated by enables
        pulse(4'h3);
        rdchk(dcir_pkg::OFF_TX_RAW, 32'h0000_0003);
        rdchk(dcir_pkg::OFF_TX_MASKED, 32'h0000_0002);
        check({28'h0, o_tx_irq}, 32'h0000_0002);
        pulse(4'hc);
        rdchk(dcir_pkg::OFF_TX_RAW, 32'h0000_000f);
        rdchk(dcir_pkg::OFF_TX_MASKED, 32'h0000_000e);
        wr(dcir_pkg::OFF_TX_EN_CLR, 32'h0000_000f);
        rdchk(dcir_pkg::OFF_TX_MASKED, 32'h0000_0000);
        check({28'h0, o_tx_irq}, 32'h0000_0000);
        wr(dcir_pkg::OFF_TX_EN_SET, 32'h0000_0009);
        rdchk(dcir_pkg::OFF_TX_MASKED, 32'h0000_0009);
        check({28'h0, o_tx_irq}, 32'h0000_0009);
        pulse(4'h1);
        check({28'h0, o_tx_irq}, 32'h0000_0009);
        $display("test completion done");
        // Receive engine bit, then an unmapped write that must not land
        wr(dcir_pkg::OFF_RX_CTRL, 32'hffff_ffff);
        rdchk(dcir_pkg::OFF_RX_CTRL, 32'h0000_0001);
        check({31'h0, o_rx_dma_on}, 32'h0000_0001);
        wr(12'h018, 32'h0000_0000);
        wr(dcir_pkg::OFF_RX_CTRL, 32'h0000_0000);
        rdchk(dcir_pkg::OFF_RX_CTRL, 32'h0000_0000);
        check({31'h0, o_rx_dma_on}, 32'h0000_0000);
        wr(dcir_pkg::OFF_RX_CTRL, 32'h0000_0001);
        wr(12'h018, 32'h0000_0000);
        rdchk(dcir_pkg::OFF_RX_CTRL, 32'h0000_0001);
        $display("test rx control done");
        // Second reset in mid-run with flags, enables and engine set
        i_intr_vector <= 32'h0000_0000;
        do_reset();
        after_reset("mid-run reset");
        summarize();
    end
endmodule : dcir_regs_tb
